// ==== hw/shc_regs.sv ====
// Sensing and haptic configuration register bank with link-side access
//
// Notes on behaviour
// RQ1 - Writing one to command bit 5 fires a haptic pulse; self-clears.
// RQ2 - Writing one to command bit 4 reloads long-term average; self-clears.
// RQ3 - Writing one to command bit 2 runs auto tune calibration; self-clears.
// RQ4 - Writing one to command bit 1 soft-resets the device; self-clears.
// RQ5 - Host acknowledges reset with command bit 0; device self-clears it.
// RQ6 - Power bit 7 set closes the window on stop; clear keeps open.
// RQ7 - Interface field: 0 streaming, 1 event, 2 reserved, 3 standalone.
// RQ8 - Power mode field: 0 normal, 1 ultra low power, 2 auto, 3 halt.
// RQ9 - In event mode, windows open only for unmasked events.
// RQ10 - Low-power register bit 6 enables the read-only check.
// RQ11 - Watchdog code selects off or 50 to 4000 ms timeout.
// RQ12 - Low-power register bit 2 enables low power near conversion.
// RQ13 - Near conversion updates after 4, 8, 16 or 32 conversions.
// RQ14 - Calibration mode: disabled, divider, compensation, or both.
// RQ15 - Sensing bit 5 raises button events on both delta signs.
// RQ16 - Sensing bit 4 raises button events on negative deltas.
// RQ17 - Second sensing bit 7 runs transmit at oscillator frequency.
// RQ18 - Sensing mode field: 0 off, 3 self capacitance, 4 inductance.
// RQ19 - Host programs conversion frequency codes 3, 7 or 15.
// RQ20 - Near state entered and left after debounce sample counts.
// RQ21 - Touch state has its own enter and exit debounce counts.
// RQ22 - Reserved bits read zero; command bits read zero once accepted.
`timescale 1ns/100ps
`default_nettype none
module shc_regs (
  input  wire logic              clock_i,      // System clock, 100 MHz
  input  wire logic              rst_b_i,      // Async reset, active low
  input  wire logic              link_clk_i,   // Link-side clock
  input  wire logic              wr_i,         // Link write pulse
  input  wire shc_pkg::shc_wr_t  wr_data_i,    // Link write address/data
  input  wire logic [15:0]       rd_addr_i,    // Link read address
  output logic [7:0]             rd_data_o,    // Link read data
  input  wire logic              stop_i,       // Link stop condition pulse
  input  wire logic              cycle_i,      // Sensing cycle tick
  input  wire shc_pkg::shc_evt_t evt_i,        // Sensing events, pulses
  input  wire logic              near_raw_i,   // Raw near sample
  input  wire logic              touch_raw_i,  // Raw touch sample
  input  wire logic              hf_sample_i,  // High-frequency sample tick
  input  wire logic              lp_conv_i,    // Low-power conversion tick
  input  wire logic              wd_kick_i,    // Watchdog service pulse
  output shc_pkg::shc_cmd_t      cmd_o,        // Command pulses
  output shc_pkg::shc_cfg_t      cfg_o,        // Decoded configuration
  output logic                   window_o,     // Comms window open
  output logic                   near_o,       // Debounced near state
  output logic                   touch_o,      // Debounced touch state
  output logic                   lp_update_o,  // Update all channels pulse
  output logic                   wd_expire_o,  // Watchdog timeout pulse
  output logic                   i2c_en_o      // I2C enabled
);
  import shc_pkg::*;

  logic       rst_s1_r, rst_b_r;
  logic [7:0] pwr_r, mask_r, lpwd_r, snsa_r, snsb_r, near_r, cont_r;
  logic [4:0] cmd_pend_r;
  logic       lw_tog_r;
  shc_wr_t    lw_hold_r;
  logic       sw_s1_r, sw_s2_r, sw_s3_r;
  logic       sync_wr;
  logic       stp_tog_r, sp_s1_r, sp_s2_r, sp_s3_r;
  logic       win_r;
  logic       win_l1_r, win_l2_r;
  logic [7:0] rd_nxt;
  logic [5:0] lp_cnt_r;
  logic [31:0] wd_cnt_r;
  logic [31:0] wd_lim;
  logic [5:0] lp_lim;
  logic       evt_hit;
  logic       s_near1_r, s_near2_r, s_touch1_r, s_touch2_r;

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r  <= rst_s1_r;
    end
  end

  // Link side: capture write and flip toggle
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lw_tog_r  <= 1'b0;
      lw_hold_r <= '0;
      stp_tog_r <= 1'b0;
    end else begin
      if (wr_i) begin
        lw_tog_r  <= ~lw_tog_r;
        lw_hold_r <= wr_data_i;
      end
      if (stop_i)
        stp_tog_r <= ~stp_tog_r;
    end
  end

  // Toggle synchronisers into the system domain
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_s1_r <= 1'b0;
      sw_s2_r <= 1'b0;
      sw_s3_r <= 1'b0;
      sp_s1_r <= 1'b0;
      sp_s2_r <= 1'b0;
      sp_s3_r <= 1'b0;
    end else begin
      sw_s1_r <= lw_tog_r;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      sp_s1_r <= stp_tog_r;
      sp_s2_r <= sp_s1_r;
      sp_s3_r <= sp_s2_r;
    end
  end
  assign sync_wr = (sw_s2_r ^ sw_s3_r) && i2c_en_o; // Standalone drops it

  // Configuration registers; reserved bits masked off
  // RQ22 reserved bits zero
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_r  <= SHC_RST_REG;
      mask_r <= SHC_RST_REG;
      lpwd_r <= SHC_RST_REG;
      snsa_r <= SHC_RST_REG;
      snsb_r <= SHC_RST_REG;
      near_r <= SHC_RST_REG;
      cont_r <= SHC_RST_REG;
    end else if (!rst_b_r || cmd_o.soft_reset) begin
      pwr_r  <= SHC_RST_REG;
      mask_r <= SHC_RST_REG;
      lpwd_r <= SHC_RST_REG;
      snsa_r <= SHC_RST_REG;
      snsb_r <= SHC_RST_REG;
      near_r <= SHC_RST_REG;
      cont_r <= SHC_RST_REG;
    end else if (sync_wr) begin
      unique case (lw_hold_r.addr)
        SHC_ADDR_PWR:  pwr_r  <= lw_hold_r.data & SHC_WM_PWR;
        SHC_ADDR_MASK: mask_r <= lw_hold_r.data & SHC_WM_MASK;
        SHC_ADDR_LPWD: lpwd_r <= lw_hold_r.data & SHC_WM_LPWD;
        SHC_ADDR_SNSA: snsa_r <= lw_hold_r.data & SHC_WM_SNSA;
        SHC_ADDR_SNSB: snsb_r <= lw_hold_r.data & SHC_WM_SNSB;
        SHC_ADDR_NEAR: near_r <= lw_hold_r.data & SHC_WM_DEB;
        SHC_ADDR_CONT: cont_r <= lw_hold_r.data & SHC_WM_DEB;
        default: ;
      endcase
    end
  end

  // Command strobes: write one pulses once, zero does nothing
  // RQ1 RQ2 RQ3 RQ4 RQ5 self-clearing strobes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_pend_r <= '0;
    end else if (!rst_b_r) begin
      cmd_pend_r <= '0;
    end else if (sync_wr && lw_hold_r.addr == SHC_ADDR_CMD) begin
      cmd_pend_r <= {lw_hold_r.data[SHC_CMD_HAPTIC],
                     lw_hold_r.data[SHC_CMD_RESEED],
                     lw_hold_r.data[SHC_CMD_CAL],
                     lw_hold_r.data[SHC_CMD_SRST],
                     lw_hold_r.data[SHC_CMD_ACK]};
    end else begin
      cmd_pend_r <= '0;
    end
  end
  assign cmd_o = shc_cmd_t'(cmd_pend_r);

  // Decoded configuration
  // RQ8 RQ7 RQ6 power fields
  always_comb begin
    cfg_o.power_mode    = shc_pm_t'(pwr_r[SHC_PWR_MD_LO +: 3]);
    cfg_o.if_select     = shc_if_t'(pwr_r[SHC_PWR_IF_LO +: 2]);
    cfg_o.close_on_stop = pwr_r[SHC_PWR_TERM];
    // RQ10 read-only check
    cfg_o.read_only_check = lpwd_r[SHC_LP_ROCHK];
    cfg_o.watchdog_code   = lpwd_r[SHC_LP_WD_LO +: 3];
    // RQ12 low power enable
    cfg_o.low_power_near_conversion = lpwd_r[SHC_LP_EN];
    cfg_o.lp_update_count = lp_lim;
    // RQ14 calibration mode
    cfg_o.calib_mode     = snsa_r[SHC_SA_CAL_LO +: 2];
    // RQ15 RQ16 delta polarity
    cfg_o.dual_threshold = snsa_r[SHC_SA_DUAL];
    cfg_o.inverse        = snsa_r[SHC_SA_INV];
    // RQ17 transmit at oscillator
    cfg_o.fosc_tx        = snsb_r[SHC_SB_FOSC];
    // RQ18 sensing mode field
    cfg_o.sensing_mode   = snsb_r[SHC_SB_MODE_LO +: 3];
    // RQ19 host-chosen frequency
    cfg_o.conv_freq      = snsb_r[SHC_SB_FREQ_LO +: 4];
  end

  // Standalone disables I2C
  // RQ7 standalone mode
  assign i2c_en_o = (cfg_o.if_select != SHC_IF_ALONE);

  // Event gating by masks
  // RQ9 masked event windows
  assign evt_hit = |(evt_i & shc_evt_t'(mask_r[4:0]));

  // Communication window open/close; open wins over close
  // RQ6 RQ7 window control
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_r <= 1'b0;
    end else if (!rst_b_r || !i2c_en_o) begin
      win_r <= 1'b0;
    end else if ((cfg_o.if_select == SHC_IF_STREAM && cycle_i) ||
                 (cfg_o.if_select == SHC_IF_EVENT && evt_hit)) begin
      win_r <= 1'b1;
    end else if ((sp_s2_r ^ sp_s3_r) && cfg_o.close_on_stop) begin
      win_r <= 1'b0;
    end
  end
  assign window_o = win_r;

  // Window level carried to the link side for read gating
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_l1_r <= 1'b0;
      win_l2_r <= 1'b0;
    end else begin
      win_l1_r <= win_r;
      win_l2_r <= win_l1_r;
    end
  end

  // Read mux; command register always reads zero
  // RQ22 command reads zero
  always_comb begin
    unique case (rd_addr_i)
      SHC_ADDR_PWR:  rd_nxt = pwr_r;
      SHC_ADDR_MASK: rd_nxt = mask_r;
      SHC_ADDR_LPWD: rd_nxt = lpwd_r;
      SHC_ADDR_SNSA: rd_nxt = snsa_r;
      SHC_ADDR_SNSB: rd_nxt = snsb_r;
      SHC_ADDR_NEAR: rd_nxt = near_r;
      SHC_ADDR_CONT: rd_nxt = cont_r;
      default:       rd_nxt = 8'h00;
    endcase
  end

  // Read data registered on the link clock; config is quasi-static
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= win_l2_r ? rd_nxt : 8'h00;
  end

  // Low-power conversion count: 4 shl code
  // RQ13 update count
  assign lp_lim = 6'd4 << lpwd_r[SHC_LP_CNT_LO +: 2];
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp_cnt_r    <= '0;
      lp_update_o <= 1'b0;
    end else if (!rst_b_r || !cfg_o.low_power_near_conversion) begin
      lp_cnt_r    <= '0;
      lp_update_o <= 1'b0;
    end else begin
      lp_update_o <= 1'b0;
      if (lp_conv_i) begin
        if (lp_cnt_r + 6'd1 >= lp_lim) begin
          lp_cnt_r    <= '0;
          lp_update_o <= 1'b1;
        end else begin
          lp_cnt_r <= lp_cnt_r + 6'd1;
        end
      end
    end
  end

  // Watchdog limit table
  // RQ11 watchdog periods
  always_comb begin
    unique case (cfg_o.watchdog_code)
      3'h0: wd_lim = 32'h0000_0000;
      3'h1: wd_lim = SHC_WD_CYC_1;
      3'h2: wd_lim = 32'(SHC_WD_MS_2 * SHC_CYC_PER_MS);
      3'h3: wd_lim = 32'(SHC_WD_MS_3 * SHC_CYC_PER_MS);
      3'h4: wd_lim = 32'(SHC_WD_MS_4 * SHC_CYC_PER_MS);
      3'h5: wd_lim = 32'(SHC_WD_MS_5 * SHC_CYC_PER_MS);
      3'h6: wd_lim = 32'(SHC_WD_MS_6 * SHC_CYC_PER_MS);
      3'h7: wd_lim = SHC_WD_CYC_7;
    endcase
  end

  // Watchdog counter, restarts on kick
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_cnt_r    <= '0;
      wd_expire_o <= 1'b0;
    end else if (!rst_b_r || wd_lim == 32'h0000_0000 || wd_kick_i) begin
      wd_cnt_r    <= '0;
      wd_expire_o <= 1'b0;
    end else if (wd_cnt_r + 32'd1 >= wd_lim) begin
      wd_cnt_r    <= '0;
      wd_expire_o <= 1'b1;
    end else begin
      wd_cnt_r    <= wd_cnt_r + 32'd1;
      wd_expire_o <= 1'b0;
    end
  end

  // Raw samples synchronised before debounce
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_near1_r  <= 1'b0;
      s_near2_r  <= 1'b0;
      s_touch1_r <= 1'b0;
      s_touch2_r <= 1'b0;
    end else begin
      s_near1_r  <= near_raw_i;
      s_near2_r  <= s_near1_r;
      s_touch1_r <= touch_raw_i;
      s_touch2_r <= s_touch1_r;
    end
  end

  // RQ20 near debounce
  shc_debounce u_near (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_r),
    .tick_i   (hf_sample_i),
    .raw_i    (s_near2_r),
    .enter_i  (near_r[SHC_DEB_ENT_LO +: 4]),
    .exit_i   (near_r[SHC_DEB_EXIT_LO +: 4]),
    .state_o  (near_o)
  );

  // RQ21 touch debounce
  shc_debounce u_touch (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_r),
    .tick_i   (hf_sample_i),
    .raw_i    (s_touch2_r),
    .enter_i  (cont_r[SHC_DEB_ENT_LO +: 4]),
    .exit_i   (cont_r[SHC_DEB_EXIT_LO +: 4]),
    .state_o  (touch_o)
  );
endmodule

// Enter/exit debounce on consecutive sample counts
module shc_debounce (
  input  wire logic       clock_i,  // System clock
  input  wire logic       rst_b_i,  // Synchronised reset, active low
  input  wire logic       tick_i,   // Sample tick
  input  wire logic       raw_i,    // Synchronised raw sample
  input  wire logic [3:0] enter_i,  // Samples to enter
  input  wire logic [3:0] exit_i,   // Samples to leave
  output logic            state_o   // Debounced state
);
  logic [3:0] cnt_r;

  // Count consecutive samples opposing the state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r   <= 4'h0;
      state_o <= 1'b0;
    end else if (tick_i) begin
      if (raw_i == state_o) begin
        cnt_r <= 4'h0;
      end else if (cnt_r + 4'h1 >= (state_o ? exit_i : enter_i)) begin
        cnt_r   <= 4'h0;
        state_o <= raw_i;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== inc/shc_pkg.sv ====
// Package for the sensing and haptic configuration register bank
package shc_pkg;
  // Register addresses, 16-bit I2C memory map
  localparam logic [15:0] SHC_ADDR_CMD   = 16'h1000;
  localparam logic [15:0] SHC_ADDR_PWR   = 16'h1001;
  localparam logic [15:0] SHC_ADDR_MASK  = 16'h1002;
  localparam logic [15:0] SHC_ADDR_LPWD  = 16'h1003;
  localparam logic [15:0] SHC_ADDR_SNSA  = 16'h1012;
  localparam logic [15:0] SHC_ADDR_SNSB  = 16'h1013;
  localparam logic [15:0] SHC_ADDR_NEAR  = 16'h1028;
  localparam logic [15:0] SHC_ADDR_CONT  = 16'h102c;
  // Writable bit masks per register, reserved bits cleared
  localparam logic [7:0] SHC_WM_PWR  = 8'he7;
  localparam logic [7:0] SHC_WM_MASK = 8'h1f;
  localparam logic [7:0] SHC_WM_LPWD = 8'h7f;
  localparam logic [7:0] SHC_WM_SNSA = 8'hf0;
  localparam logic [7:0] SHC_WM_SNSB = 8'hff;
  localparam logic [7:0] SHC_WM_DEB  = 8'hff;
  // Reset values
  localparam logic [7:0] SHC_RST_REG = 8'h00;
  // Command bit positions
  localparam int SHC_CMD_HAPTIC = 5;
  localparam int SHC_CMD_RESEED = 4;
  localparam int SHC_CMD_CAL    = 2;
  localparam int SHC_CMD_SRST   = 1;
  localparam int SHC_CMD_ACK    = 0;
  // Power settings fields
  localparam int SHC_PWR_TERM   = 7;
  localparam int SHC_PWR_IF_LO  = 5;
  localparam int SHC_PWR_MD_LO  = 0;
  // Low-power / watchdog fields
  localparam int SHC_LP_ROCHK   = 6;
  localparam int SHC_LP_WD_LO   = 3;
  localparam int SHC_LP_EN      = 2;
  localparam int SHC_LP_CNT_LO  = 0;
  // Sensing settings fields
  localparam int SHC_SA_CAL_LO  = 6;
  localparam int SHC_SA_DUAL    = 5;
  localparam int SHC_SA_INV     = 4;
  localparam int SHC_SB_FOSC    = 7;
  localparam int SHC_SB_MODE_LO = 4;
  localparam int SHC_SB_FREQ_LO = 0;
  localparam int SHC_DEB_EXIT_LO = 4;
  localparam int SHC_DEB_ENT_LO  = 0;
  // Watchdog periods in ms and cycles at 100 MHz
  localparam int SHC_CLK_MHZ = 100;
  localparam int SHC_WD_MS_1 = 50;
  localparam int SHC_WD_MS_2 = 125;
  localparam int SHC_WD_MS_3 = 250;
  localparam int SHC_WD_MS_4 = 500;
  localparam int SHC_WD_MS_5 = 1000;
  localparam int SHC_WD_MS_6 = 2000;
  localparam int SHC_WD_MS_7 = 4000;
  localparam int SHC_CYC_PER_MS = SHC_CLK_MHZ * 1000;
  localparam logic [31:0] SHC_WD_CYC_1 = 32'(SHC_WD_MS_1 * SHC_CYC_PER_MS);
  localparam logic [31:0] SHC_WD_CYC_7 = 32'(SHC_WD_MS_7 * SHC_CYC_PER_MS);

  // Interface select codes
  typedef enum logic [1:0] {
    SHC_IF_STREAM = 2'h0,
    SHC_IF_EVENT  = 2'h1,
    SHC_IF_RSVD   = 2'h2,
    SHC_IF_ALONE  = 2'h3
  } shc_if_t;
  // Power mode codes
  typedef enum logic [2:0] {
    SHC_PM_NORMAL = 3'h0,
    SHC_PM_ULP    = 3'h1,
    SHC_PM_AUTO   = 3'h2,
    SHC_PM_HALT   = 3'h3
  } shc_pm_t;

  // Command strobes out, one-cycle pulses in system domain
  typedef struct packed {
    logic haptic_trigger;
    logic reseed_long_term_average;
    logic auto_tune_calibration;
    logic soft_reset;
    logic reset_ack;
  } shc_cmd_t;

  // Sensing events from the core, one bit each
  typedef struct packed {
    logic haptic;
    logic touch;
    logic near;
    logic calibration;
    logic power_mode;
  } shc_evt_t;

  // Decoded configuration toward the sensing core
  typedef struct packed {
    shc_pm_t    power_mode;
    shc_if_t    if_select;
    logic       close_on_stop;
    logic       read_only_check;
    logic [2:0] watchdog_code;
    logic       low_power_near_conversion;
    logic [5:0] lp_update_count;
    logic [1:0] calib_mode;
    logic       dual_threshold;
    logic       inverse;
    logic       fosc_tx;
    logic [2:0] sensing_mode;
    logic [3:0] conv_freq;
  } shc_cfg_t;

  // Register write from the link side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } shc_wr_t;
endpackage

// ==== test/shc_link_host.sv ====
// Link-side host model for the register bank access port
`timescale 1ns/100ps
`default_nettype none
module shc_link_host (
  output logic             link_clk_o, // Link clock, still when idle
  output logic             wr_o,       // Write pulse
  output shc_pkg::shc_wr_t wr_data_o,  // Write address and data
  output logic [15:0]      rd_addr_o,  // Read address
  input  wire logic [7:0]  rd_data_i,  // Read data
  output logic             stop_o      // Stop condition pulse
);
  import shc_pkg::*;
  logic run_en = 1'b1; // Clock runs while set
  // Gated link clock, phase unrelated to the system clock
  initial begin
    link_clk_o = 1'b0;
    wr_o = 1'b0;
    wr_data_o = '0;
    rd_addr_o = 16'h0000;
    stop_o = 1'b0;
    #3.3;
    forever begin
      link_clk_o = run_en ? ~link_clk_o : 1'b0;
      #16;
    end
  end
  // Start the clock and let the window settle in the link domain
  task automatic lead();
    run_en = 1'b1;
    repeat (3) @(posedge link_clk_o);
    #1;
  endtask
  // One write, then the spacing the crossing needs
  task automatic write(input logic [15:0] a, input logic [7:0] d);
    lead();
    wr_o = 1'b1;
    wr_data_o = '{addr: a, data: d};
    @(posedge link_clk_o);
    #1;
    wr_o = 1'b0;
    wr_data_o = ~wr_data_o;
    repeat (4) @(posedge link_clk_o);
    run_en = 1'b0;
  endtask
  // Read one byte; the address is scrambled once released
  task automatic read(input logic [15:0] a, output logic [7:0] d);
    lead();
    rd_addr_o = a;
    @(posedge link_clk_o);
    #1;
    d = rd_data_i;
    rd_addr_o = ~a;
    @(posedge link_clk_o);
    run_en = 1'b0;
  endtask
  // Stop condition, then room for it to cross
  task automatic stop();
    lead();
    stop_o = 1'b1;
    @(posedge link_clk_o);
    #1;
    stop_o = 1'b0;
    repeat (4) @(posedge link_clk_o);
    run_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/shc_regs_sva.sv ====
// Port checker for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module shc_regs_sva (
  input wire logic              clock_i,     // System clock
  input wire logic              rst_b_i,     // Reset, active low
  input wire logic              link_clk_i,  // Link clock
  input wire logic [15:0]       rd_addr_i,   // Link read address
  input wire logic [7:0]        rd_data_o,   // Link read data
  input wire shc_pkg::shc_cmd_t cmd_o,       // Command pulses
  input wire shc_pkg::shc_cfg_t cfg_o,       // Decoded configuration
  input wire logic              lp_update_o, // Update-all pulse
  input wire logic              i2c_en_o     // I2C enabled
);
  import shc_pkg::*;
  // Command strobes clear themselves after one cycle
  a_haptic_pulse: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) cmd_o.haptic_trigger |=> !cmd_o.haptic_trigger)
    else $error("haptic strobe held");
  a_reseed_pulse: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) cmd_o.reseed_long_term_average
    |-> ##1 !cmd_o.reseed_long_term_average) else $error("reseed held");
  a_cal_pulse: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) $rose(cmd_o.auto_tune_calibration)
    |=> $fell(cmd_o.auto_tune_calibration)) else $error("tune held");
  a_srst_pulse: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) cmd_o.soft_reset |=> !cmd_o.soft_reset)
    else $error("soft reset held");
  a_ack_pulse: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) cmd_o.reset_ack |=> !cmd_o.reset_ack)
    else $error("reset ack held");
  // Standalone code turns the link off
  a_standalone_no_i2c: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) i2c_en_o == (cfg_o.if_select != SHC_IF_ALONE))
    else $error("link enable disagrees with mode");
  // Update pulses only with the scheme enabled
  a_lp_update_gated: assert property (@(posedge clock_i)
    disable iff (!rst_b_i) lp_update_o |-> cfg_o.low_power_near_conversion
    || $past(cfg_o.low_power_near_conversion)) else $error("update while off");
  // Read side: commands, power register reserved bits and addresses outside 0x1000-0x1fff read zero
  a_cmd_reads_zero: assert property (@(posedge link_clk_i)
    disable iff (!rst_b_i) rd_addr_i == SHC_ADDR_CMD |=> rd_data_o == 8'h00)
    else $error("command register read nonzero");
  a_pwr_reserved_zero: assert property (@(posedge link_clk_i)
    disable iff (!rst_b_i) rd_addr_i == SHC_ADDR_PWR
    |=> (rd_data_o & ~SHC_WM_PWR) == 8'h00) else $error("reserved bit set");
  a_unmapped_reads_zero: assert property (@(posedge link_clk_i)
    disable iff (!rst_b_i) rd_addr_i[15:12] != 4'h1 |=> rd_data_o == 8'h00)
    else $error("unmapped read nonzero");
endmodule
bind shc_regs shc_regs_sva chk_u (
  .clock_i     (clock_i),
  .rst_b_i     (rst_b_i),
  .link_clk_i  (link_clk_i),
  .rd_addr_i   (rd_addr_i),
  .rd_data_o   (rd_data_o),
  .cmd_o       (cmd_o),
  .cfg_o       (cfg_o),
  .lp_update_o (lp_update_o),
  .i2c_en_o    (i2c_en_o)
);
`default_nettype wire

// ==== test/shc_regs_tb_top.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module shc_regs_tb_top;
  import shc_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        link_clk_i, wr_i, stop_i;
  shc_wr_t     wr_data_i;
  logic [15:0] rd_addr_i;
  logic [7:0]  rd_data_o;
  logic        cycle_i = 1'b0, lp_conv_i = 1'b0;
  shc_evt_t    evt_i = '0;
  logic        near_raw_i = 1'b0, touch_raw_i = 1'b0;
  logic        hf_sample_i = 1'b0;
  shc_cmd_t    cmd_o;
  shc_cmd_t    cmd_seen = '0;
  shc_cfg_t    cfg_o;
  logic        window_o, near_o, touch_o, lp_update_o, wd_expire_o, i2c_en_o;
  int          error_cnt = 0, tests_run = 0;
  int          cmd_cyc = 0, upd_cnt = 0;
  int          cb [5] = '{5, 4, 2, 1, 0};
  logic [15:0] ra [8] = '{SHC_ADDR_CMD, SHC_ADDR_MASK, SHC_ADDR_LPWD,
    SHC_ADDR_SNSA, SHC_ADDR_SNSB, SHC_ADDR_NEAR, SHC_ADDR_CONT, 16'h1004};
  logic [7:0]  wm [8] = '{8'h00, SHC_WM_MASK, SHC_WM_LPWD, SHC_WM_SNSA,
    SHC_WM_SNSB, SHC_WM_DEB, SHC_WM_DEB, 8'h00};
  logic [2:0]  sm [3] = '{3'h0, 3'h3, 3'h4};
  logic [3:0]  sf [3] = '{4'h3, 4'h7, 4'hf};

  shc_regs dut_u (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i),
    .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .stop_i(stop_i), .cycle_i(cycle_i),
    .evt_i(evt_i), .near_raw_i(near_raw_i), .touch_raw_i(touch_raw_i),
    .hf_sample_i(hf_sample_i), .lp_conv_i(lp_conv_i), .wd_kick_i(1'b0),
    .cmd_o(cmd_o), .cfg_o(cfg_o), .window_o(window_o), .near_o(near_o),
    .touch_o(touch_o), .lp_update_o(lp_update_o),
    .wd_expire_o(wd_expire_o), .i2c_en_o(i2c_en_o));
  shc_link_host host_u (
    .link_clk_o(link_clk_i), .wr_o(wr_i), .wr_data_o(wr_data_i),
    .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o), .stop_o(stop_i));

  // System clock
  always #5 clock_i = ~clock_i;
  // Collect pulses
  always @(posedge clock_i) begin
    cmd_seen <= cmd_seen | cmd_o;
    if (cmd_o != '0) cmd_cyc <= cmd_cyc + 1;
    if (lp_update_o) upd_cnt <= upd_cnt + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask
  // Pulse a cycle tick, which opens a window in streaming mode only, then read and compare
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cycle_i = 1'b1;
    step(1);
    cycle_i = 1'b0;
    step(2);
    host_u.read(a, d);
    check8("read", e, d);
  endtask
  task automatic evt_pulse(input shc_evt_t e);
    evt_i = e;
    step(1);
    evt_i = '0;
    step(3);
  endtask
  // State moves only on the last of n agreeing samples
  task automatic deb(input logic t, input logic [3:0] ni, input logic [3:0] no);
    logic lvl;
    for (int p = 0; p < 2; p++) begin
      lvl = (p == 0);
      if (t) touch_raw_i = lvl;
      else near_raw_i = lvl;
      step(4);
      for (int s = 1; s <= (p ? no : ni); s++) begin
        hf_sample_i = 1'b1;
        step(1);
        hf_sample_i = 1'b0;
        step(3);
        check8("debounce", 8'((s == (p ? no : ni)) ? lvl : !lvl),
               8'(t ? touch_o : near_o));
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    step(4);
    foreach (ra[i]) rd_chk(ra[i], 8'h00);
    foreach (ra[i]) begin
      host_u.write(ra[i], 8'hff);
      rd_chk(ra[i], wm[i]);
    end
    host_u.write(SHC_ADDR_PWR, 8'h9f);
    rd_chk(SHC_ADDR_PWR, 8'h87);
    for (int v = 0; v < 8; v++) begin
      host_u.write(SHC_ADDR_LPWD, {1'b1, v[0], v[2:0], v[1], v[1:0]});
      check8("wd", 8'(v), 8'(cfg_o.watchdog_code));
      check8("ro", 8'(v[0]), 8'(cfg_o.read_only_check));
      check8("lp", 8'(v[1]), 8'(cfg_o.low_power_near_conversion));
      check8("lpn", 8'(4 << v[1:0]), 8'(cfg_o.lp_update_count));
      host_u.write(SHC_ADDR_PWR, {v[2], 4'h0, v[2:0]});
      check8("pm", 8'(v), 8'(cfg_o.power_mode));
      check8("term", 8'(v[2]), 8'(cfg_o.close_on_stop));
      host_u.write(SHC_ADDR_SNSA, {v[1:0], v[0], v[1], 4'hf});
      check8("cal", 8'(v[1:0]), 8'(cfg_o.calib_mode));
      check8("dual", 8'(v[0]), 8'(cfg_o.dual_threshold));
      check8("inv", 8'(v[1]), 8'(cfg_o.inverse));
    end
    for (int m = 0; m < 3; m++) begin
      host_u.write(SHC_ADDR_SNSB, {m[0], sm[m], sf[m]});
      check8("fosc", 8'(m[0]), 8'(cfg_o.fosc_tx));
      check8("mode", 8'(sm[m]), 8'(cfg_o.sensing_mode));
      check8("freq", 8'(sf[m]), 8'(cfg_o.conv_freq));
    end
    for (int k = 0; k < 6; k++) begin
      cmd_seen = '0;
      cmd_cyc = 0;
      host_u.write(SHC_ADDR_CMD, (k < 5) ? 8'(1 << cb[k]) : 8'hc8);
      check8("cmd", 8'(5'b10000 >> k), 8'(cmd_seen));
      check8("cmd_len", (k < 5) ? 8'h01 : 8'h00, 8'(cmd_cyc));
    end
    check8("srst", 8'h00, 8'(cfg_o.calib_mode));
    host_u.write(SHC_ADDR_MASK, 8'h04);
    host_u.write(SHC_ADDR_PWR, 8'ha0);
    host_u.stop();
    step(4);
    check8("win_stop", 8'h00, 8'(window_o));
    rd_chk(SHC_ADDR_MASK, 8'h00);
    check8("win_cyc", 8'h00, 8'(window_o));
    evt_pulse(5'b01000);
    check8("win_mask", 8'h00, 8'(window_o));
    evt_pulse(5'b00100);
    check8("win_evt", 8'h01, 8'(window_o));
    rd_chk(SHC_ADDR_MASK, 8'h04);
    host_u.write(SHC_ADDR_PWR, 8'h20);
    host_u.stop();
    step(4);
    check8("win_keep", 8'h01, 8'(window_o));
    for (int e = 0; e < 2; e++) begin
      host_u.write(SHC_ADDR_LPWD, e ? 8'h01 : 8'h05);
      upd_cnt = 0;
      repeat (16) begin
        lp_conv_i = 1'b1;
        step(1);
        lp_conv_i = 1'b0;
        step(1);
      end
      step(3);
      check8("lp_upd", e ? 8'h00 : 8'h02, 8'(upd_cnt));
    end
    check8("wd_off", 8'h00, 8'(wd_expire_o));
    host_u.write(SHC_ADDR_NEAR, 8'h23);
    deb(1'b0, 4'h3, 4'h2);
    host_u.write(SHC_ADDR_CONT, 8'h12);
    deb(1'b1, 4'h2, 4'h1);
    host_u.write(SHC_ADDR_PWR, 8'h60);
    check8("i2c_off", 8'h00, 8'(i2c_en_o));
    host_u.write(SHC_ADDR_SNSA, 8'hf0);
    check8("ignored", 8'h00, 8'(cfg_o.calib_mode));
    rst_b_i = 1'b0;
    step(8);
    rst_b_i = 1'b1;
    step(4);
    check8("i2c_on", 8'h01, 8'(i2c_en_o));
    report_and_stop();
  end
  // Cut a hang short
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
